/* core/rtc_consts.svh */
// Constants for the counter and periodic tick block: indices, fields, resets, timing
// How it works
// - Count equal to limit wraps to zero, flags
// - Count equal to compare sets match flag
// - Tick flag set each selected period elapsed
// - Irq asserted while enable and flag set
// - Separate flags, enables, irq for counter, tick
// - Counter runs idle; standby only if enabled
// - Tick generator runs in every sleep mode
// - Logic on counter clock; updates take sync delay
// - Busy flags for compare, limit, count, control
// - Busy flag for tick control synchronization
// - Halt stops counter unless run-while-halted set
// - Halt forces tick output low unless allowed
// - Resume with tick high gives fresh edge
// - Divider divides counter clock by two^field
// - Control write acts after two counter clocks
// - Control resets zero; bit7, bits6:3, bit0
// - Prescaler stops when both enables are clear
// - Writing one clears flag, zero leaves it
// - Two-bit source select picks counter clock
// - Shared byte latch gives atomic 16-bit access
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_MAIN_CONTROL  6'h00
`define IDX_SYNC_STATUS   6'h01
`define IDX_IRQ_ENABLE    6'h02
`define IDX_IRQ_FLAGS     6'h03
`define IDX_LATCH         6'h04
`define IDX_HALT          6'h05
`define IDX_SOURCE        6'h07
`define IDX_COUNT_LO      6'h08
`define IDX_COUNT_HI      6'h09
`define IDX_LIMIT_LO      6'h0A
`define IDX_LIMIT_HI      6'h0B
`define IDX_MATCH_LO      6'h0C
`define IDX_MATCH_HI      6'h0D
`define IDX_TICK_CONTROL  6'h10
`define IDX_TICK_STATUS   6'h11
`define IDX_TICK_IRQ_EN   6'h12
`define IDX_TICK_FLAG     6'h13
`define IDX_TICK_HALT     6'h15

// Field positions
`define BIT_WRAP          0
`define BIT_MATCH         1
`define CTRL_WMASK        8'hF9
`define TICK_WMASK        8'h79

// Synchronization channels, in busy status bit order
`define SYNC_CTRL         0
`define SYNC_COUNT        1
`define SYNC_LIMIT        2
`define SYNC_MATCH        3
`define SYNC_TICK         4
`define SYNC_CHANNELS     5
`define SYNC_TICKS        2'h2

// Source select codes
`define SRC_INT32K        2'h0
`define SRC_INT1K         2'h1
`define SRC_XTAL          2'h2
`define SRC_EXT           2'h3

// Tick period codes that select no prescaler bit
`define PERIOD_OFF        4'h0
`define PERIOD_NONE       4'hF

// Reset values
`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000
`define RESET_LIMIT       16'hFFFF
`define RESET_PRESC       15'h0000
`define PRESC_ONE         15'h0001

`endif

/* core/rtc_counter_tick.sv */
// Real-time counter with periodic tick generator behind an APB slave
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`include "rtc_consts.svh"

module rtc_counter_tick
  import rtc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        src_int32k,
  input  wire logic        src_int1k,
  input  wire logic        src_xtal,
  input  wire logic        src_ext,
  input  wire logic        sleep_standby,
  input  wire logic        debug_halt,
  output logic             irq_counter,
  output logic             irq_tick
);

  // Bus decode
  logic [5:0]             idx;          // Word index
  logic                   access;       // Access phase seen
  logic                   done;         // Transfer completes this edge
  logic                   wr;           // Write completes
  logic                   rd;           // Read completes
  logic                   mapped;       // Index names a register
  logic [7:0]             wdat;         // Write byte
  logic [7:0]             rd_byte;      // Read mux output

  // Software-visible registers
  main_control_type       stage_ctrl;   // Control as written
  main_control_type       act_ctrl;     // Control in force
  tick_control_type       stage_tick;   // Tick control as written
  tick_control_type       act_tick;     // Tick control in force
  logic [1:0]             irq_en;       // Match and wrap enables
  logic [1:0]             flags;        // Match and wrap flags
  logic                   tick_irq_en;  // Tick enable
  logic                   tick_flag;    // Tick flag
  logic [7:0]             latch;        // Shared byte latch: low byte on writes, high byte on reads
  logic                   run_halted;   // Counter runs in halt
  logic                   tick_halted;  // Tick runs in halt
  logic [1:0]             src_sel;      // Counter clock source
  logic [15:0]            count;        // Live count
  logic [15:0]            stage_count;  // Count waiting to load
  logic [15:0]            stage_limit;  // Limit as written
  logic [15:0]            act_limit;    // Limit in force
  logic [15:0]            stage_match;  // Compare as written
  logic [15:0]            act_match;    // Compare in force

  // Counter clock domain emulation
  logic                   src_now;      // Selected source level
  logic                   src_prev;     // Level one cycle ago
  logic                   rtc_tick;     // One counter clock edge
  logic [14:0]            presc;        // Shared prescaler
  logic [15:0]            presc_ext;    // Prescaler padded for index
  logic [15:0]            div_full;     // One shifted by divider
  logic [14:0]            div_mask;     // Low prescaler bits to fill
  logic                   presc_run;    // Either function enabled
  logic                   counter_run;  // Counter allowed to step
  logic                   count_event;  // Prescaled step
  logic                   wrap_set;     // Wrap happens now
  logic                   match_set;    // Match happens now
  logic                   tick_valid;   // Period code selects a bit
  logic                   tick_out;     // Tick output level
  logic                   tick_prev;    // Tick output last cycle
  logic                   tick_set;     // Tick rising edge
  logic [1:0]             flag_clr;     // Write-one-to-clear mask
  logic                   tick_clr;     // Tick flag clear

  // Synchronization
  logic [`SYNC_CHANNELS-1:0] wr_sync;   // Write into a synced register
  logic [`SYNC_CHANNELS-1:0] busy;      // Still synchronizing
  logic [`SYNC_CHANNELS-1:0] apply;     // Value takes effect now

  // Bus phase terms
  assign idx    = paddr[7:2];
  assign access = psel & penable;
  assign done   = access & pready;
  assign wr     = done & pwrite;
  assign rd     = done & ~pwrite;
  assign wdat   = pwdata[7:0];

  // Address map check; misaligned byte addresses are unmapped
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      unique case (idx)
        `IDX_MAIN_CONTROL, `IDX_SYNC_STATUS, `IDX_IRQ_ENABLE,
        `IDX_IRQ_FLAGS, `IDX_LATCH, `IDX_HALT, `IDX_SOURCE,
        `IDX_COUNT_LO, `IDX_COUNT_HI, `IDX_LIMIT_LO, `IDX_LIMIT_HI,
        `IDX_MATCH_LO, `IDX_MATCH_HI, `IDX_TICK_CONTROL,
        `IDX_TICK_STATUS, `IDX_TICK_IRQ_EN, `IDX_TICK_FLAG,
        `IDX_TICK_HALT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // Read mux; high bytes come from the latch so the pair reads atomically
  always_comb begin
    rd_byte = `RESET_BYTE;
    unique case (idx)
      `IDX_MAIN_CONTROL: rd_byte = stage_ctrl;
      `IDX_SYNC_STATUS:  rd_byte = {4'h0, busy[`SYNC_MATCH:`SYNC_CTRL]};
      `IDX_IRQ_ENABLE:   rd_byte = {6'h00, irq_en};
      `IDX_IRQ_FLAGS:    rd_byte = {6'h00, flags};
      `IDX_LATCH:        rd_byte = latch;
      `IDX_HALT:         rd_byte = {7'h00, run_halted};
      `IDX_SOURCE:       rd_byte = {6'h00, src_sel};
      `IDX_COUNT_LO:     rd_byte = count[7:0];
      `IDX_LIMIT_LO:     rd_byte = stage_limit[7:0];
      `IDX_MATCH_LO:     rd_byte = stage_match[7:0];
      `IDX_COUNT_HI,
      `IDX_LIMIT_HI,
      `IDX_MATCH_HI:     rd_byte = latch;
      `IDX_TICK_CONTROL: rd_byte = stage_tick;
      `IDX_TICK_STATUS:  rd_byte = {7'h00, busy[`SYNC_TICK]};
      `IDX_TICK_IRQ_EN:  rd_byte = {7'h00, tick_irq_en};
      `IDX_TICK_FLAG:    rd_byte = {7'h00, tick_flag};
      `IDX_TICK_HALT:    rd_byte = {7'h00, tick_halted};
      default:           rd_byte = `RESET_BYTE;
    endcase
    if (!mapped) begin
      rd_byte = `RESET_BYTE;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= {24'h00_0000, `RESET_BYTE};
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        pslverr <= ~mapped;
        prdata  <= {24'h00_0000, rd_byte};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Writes into registers that cross into the counter clock domain
  always_comb begin
    wr_sync = '0;
    if (wr & mapped) begin
      wr_sync[`SYNC_CTRL]  = (idx == `IDX_MAIN_CONTROL);
      wr_sync[`SYNC_COUNT] = (idx == `IDX_COUNT_HI);
      wr_sync[`SYNC_LIMIT] = (idx == `IDX_LIMIT_HI);
      wr_sync[`SYNC_MATCH] = (idx == `IDX_MATCH_HI);
      wr_sync[`SYNC_TICK]  = (idx == `IDX_TICK_CONTROL);
    end
  end

  // Per-register sync tracker: busy until two counter clock edges pass.
  // A second write while busy restarts the wait; software should not do it.
  genvar g;
  generate
    for (g = 0; g < `SYNC_CHANNELS; g++) begin : g_sync
      logic [1:0] phase; // Counter clock edges seen since write
      assign apply[g] = busy[g] & rtc_tick & (phase == `SYNC_TICKS - 2'h1);
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          busy[g] <= 1'b0;
          phase   <= 2'h0;
        end else if (wr_sync[g]) begin
          busy[g] <= 1'b1;
          phase   <= 2'h0;
        end else if (apply[g]) begin
          busy[g] <= 1'b0;
          phase   <= 2'h0;
        end else if (busy[g] & rtc_tick) begin
          phase <= phase + 2'h1;
        end
      end
    end
  endgenerate

  // Plain configuration registers written straight from the bus
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_ctrl  <= main_control_type'(`RESET_BYTE);
      stage_tick  <= tick_control_type'(`RESET_BYTE);
      irq_en      <= 2'h0;
      tick_irq_en <= 1'b0;
      run_halted  <= 1'b0;
      tick_halted <= 1'b0;
      src_sel     <= `SRC_INT32K;
    end else if (wr & mapped) begin
      unique case (idx)
        `IDX_MAIN_CONTROL: stage_ctrl  <= main_control_type'(wdat & `CTRL_WMASK);
        `IDX_TICK_CONTROL: stage_tick  <= tick_control_type'(wdat & `TICK_WMASK);
        `IDX_IRQ_ENABLE:   irq_en      <= wdat[1:0];
        `IDX_TICK_IRQ_EN:  tick_irq_en <= wdat[0];
        `IDX_HALT:         run_halted  <= wdat[0];
        `IDX_TICK_HALT:    tick_halted <= wdat[0];
        `IDX_SOURCE:       src_sel     <= wdat[1:0];
        default: begin
        end
      endcase
    end
  end

  // Shared latch: low-byte write parks data, low-byte read captures high byte
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      latch <= `RESET_BYTE;
    end else if (wr & mapped) begin
      if (idx == `IDX_LATCH || idx == `IDX_COUNT_LO ||
          idx == `IDX_LIMIT_LO || idx == `IDX_MATCH_LO) begin
        latch <= wdat;
      end
    end else if (rd & mapped) begin
      unique case (idx)
        `IDX_COUNT_LO: latch <= count[15:8];
        `IDX_LIMIT_LO: latch <= stage_limit[15:8];
        `IDX_MATCH_LO: latch <= stage_match[15:8];
        default: begin
        end
      endcase
    end
  end

  // Sixteen-bit values staged on the high-byte write, with the latch as low byte
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_count <= `RESET_WORD;
      stage_limit <= `RESET_LIMIT;
      stage_match <= `RESET_WORD;
    end else begin
      if (wr_sync[`SYNC_COUNT]) begin
        stage_count <= {wdat, latch};
      end
      if (wr_sync[`SYNC_LIMIT]) begin
        stage_limit <= {wdat, latch};
      end
      if (wr_sync[`SYNC_MATCH]) begin
        stage_match <= {wdat, latch};
      end
    end
  end

  // Values in force, loaded only when synchronization finishes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      act_ctrl  <= main_control_type'(`RESET_BYTE);
      act_tick  <= tick_control_type'(`RESET_BYTE);
      act_limit <= `RESET_LIMIT;
      act_match <= `RESET_WORD;
    end else begin
      if (apply[`SYNC_CTRL]) begin
        act_ctrl <= stage_ctrl;
      end
      if (apply[`SYNC_TICK]) begin
        act_tick <= stage_tick;
      end
      if (apply[`SYNC_LIMIT]) begin
        act_limit <= stage_limit;
      end
      if (apply[`SYNC_MATCH]) begin
        act_match <= stage_match;
      end
    end
  end

  // Counter clock source mux
  always_comb begin
    unique case (src_sel)
      `SRC_INT32K: src_now = src_int32k;
      `SRC_INT1K:  src_now = src_int1k;
      `SRC_XTAL:   src_now = src_xtal;
      `SRC_EXT:    src_now = src_ext;
    endcase
  end

  // Rising edge of the selected source stands in for one counter clock.
  // Sources must be slower than half of mclk or edges are missed.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_now;
    end
  end
  assign rtc_tick = src_now & ~src_prev;

  // Prescaler runs while either function is on, otherwise held cleared
  assign presc_run = act_ctrl.counter_enable | act_tick.tick_enable;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc <= `RESET_PRESC;
    end else if (!presc_run) begin
      presc <= `RESET_PRESC;
    end else if (rtc_tick) begin
      presc <= presc + `PRESC_ONE;
    end
  end

  // A step comes when the low divider bits are all ones: divide by 2^field
  assign div_full    = 16'h0001 << act_ctrl.divider;
  assign div_mask    = div_full[14:0] - `PRESC_ONE;
  assign counter_run = act_ctrl.counter_enable
                     & ~(sleep_standby & ~act_ctrl.keep_running_standby)
                     & ~(debug_halt & ~run_halted);
  assign count_event = rtc_tick & counter_run & ((presc & div_mask) == div_mask);
  assign wrap_set    = count_event & (count == act_limit);
  assign match_set   = count_event & (count == act_match);

  // Live count: a synced load wins over a step
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= `RESET_WORD;
    end else if (apply[`SYNC_COUNT]) begin
      count <= stage_count;
    end else if (wrap_set) begin
      count <= `RESET_WORD;
    end else if (count_event) begin
      count <= count + 16'h0001;
    end
  end

  // Tick picks one prescaler bit; the halt gate forces it low
  assign presc_ext  = {1'b0, presc};
  assign tick_valid = (act_tick.period != `PERIOD_OFF) & (act_tick.period != `PERIOD_NONE);
  assign tick_out   = act_tick.tick_enable & tick_valid & presc_ext[act_tick.period]
                    & ~(debug_halt & ~tick_halted);

  // Edge detector; a release while the bit is high gives a fresh edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_prev <= 1'b0;
    end else begin
      tick_prev <= tick_out;
    end
  end
  assign tick_set = tick_out & ~tick_prev;

  // Write-one-to-clear masks
  assign flag_clr = (wr & mapped & (idx == `IDX_IRQ_FLAGS)) ? wdat[1:0] : 2'h0;
  assign tick_clr = wr & mapped & (idx == `IDX_TICK_FLAG) & wdat[0];

  // Sticky flags; a set in the same cycle as a clear wins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags     <= 2'h0;
      tick_flag <= 1'b0;
    end else begin
      flags[`BIT_WRAP]  <= (flags[`BIT_WRAP] & ~flag_clr[`BIT_WRAP]) | wrap_set;
      flags[`BIT_MATCH] <= (flags[`BIT_MATCH] & ~flag_clr[`BIT_MATCH]) | match_set;
      tick_flag         <= (tick_flag & ~tick_clr) | tick_set;
    end
  end

  // Two request lines, held while enable and flag stand together
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_counter <= 1'b0;
      irq_tick    <= 1'b0;
    end else begin
      irq_counter <= |(flags & irq_en);
      irq_tick    <= tick_flag & tick_irq_en;
    end
  end

endmodule

/* core/rtc_pkg.sv */
// Types shared by the counter and periodic tick block
package rtc_pkg;

  // Main control layout
  typedef struct packed {
    logic       keep_running_standby;
    logic [3:0] divider;
    logic [1:0] reserved;
    logic       counter_enable;
  } main_control_type;

  // Tick control layout
  typedef struct packed {
    logic       reserved_hi;
    logic [3:0] period;
    logic [1:0] reserved_lo;
    logic       tick_enable;
  } tick_control_type;

endpackage

/* testbench/rtc_counter_tick_properties.sv */
// Bus handshake and interrupt hold properties of the counter and tick block
`timescale 1ns/1ns
module rtc_counter_tick_properties (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_counter,
  input wire logic        irq_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Completing writes that may legally drop an interrupt line
  wire logic done_wr   = psel && penable && pready && pwrite;
  wire logic clr_count = done_wr && (paddr == 8'h0C || paddr == 8'h08);
  wire logic clr_tick  = done_wr && (paddr == 8'h4C || paddr == 8'h48);

  // Access cycle still waiting for the answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // Waiting access aimed at a hole or a misaligned byte
  sequence s_bad;
    s_wait ##0 (paddr[1:0] != 2'h0 || paddr[7:2] == 6'h06);
  endsequence

  property p_one_wait;
    s_wait |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_cause;
    !(psel && penable) |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h00_0000;
  endproperty
  property p_bad_addr;
    s_bad |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  property p_good_addr;
    s_wait ##0 (paddr == 8'h0C || paddr == 8'h4C) |=> !pslverr;
  endproperty
  // A request line only falls one or two cycles after software clears it
  property p_count_hold;
    $fell(irq_counter) |-> $past(clr_count) || $past(clr_count, 2);
  endproperty
  property p_tick_hold;
    $fell(irq_tick) |-> $past(clr_tick) || $past(clr_tick, 2);
  endproperty

  a_one_wait:    assert property (p_one_wait) else $error("no answer after one wait");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  a_err_ready:   assert property (p_err_ready) else $error("error without ready");
  a_upper_zero:  assert property (p_upper_zero) else $error("upper read bits set");
  a_bad_addr:    assert property (p_bad_addr) else $error("bad address not refused");
  a_good_addr:   assert property (p_good_addr) else $error("mapped address refused");
  a_count_hold:  assert property (p_count_hold) else $error("counter irq dropped");
  a_tick_hold:   assert property (p_tick_hold) else $error("tick irq dropped");
endmodule

bind rtc_counter_tick rtc_counter_tick_properties u_rtc_counter_tick_properties (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_counter(irq_counter), .irq_tick(irq_tick)
);

/* testbench/testbench.sv */
// Self-checking bench for the counter and periodic tick block
`timescale 1ns/1ns
module testbench;
  logic        mclk, sys_rst, psel, penable, pwrite, sleep_standby, debug_halt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, a0;
  logic        pready, pslverr, irq_counter, irq_tick, e;
  logic        src_int32k = 1'b0, src_int1k = 1'b0, src_xtal = 1'b0, src_ext = 1'b0;
  logic [3:0]  sm = 4'h1;  // Sources allowed to toggle
  logic [1:0]  ph = 2'h0;  // Source phase divider
  int          bad_count, n_compared;
  logic [7:0]  rz[13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h1C, 8'h20, 8'h30,
                          8'h40, 8'h44, 8'h48, 8'h4C, 8'h54};

  rtc_counter_tick u_rtc_counter_tick (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_int32k(src_int32k), .src_int1k(src_int1k), .src_xtal(src_xtal),
    .src_ext(src_ext), .sleep_standby(sleep_standby), .debug_halt(debug_halt),
    .irq_counter(irq_counter), .irq_tick(irq_tick));

  // Bus clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Selected sources square waves, one rising edge every four bus clocks
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    {src_ext, src_xtal, src_int1k, src_int32k} <= {4{ph[1]}} & sm;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic chk1(input logic s, input logic x);
    chk({31'h0000_0000, s}, {31'h0000_0000, x});
  endtask

  // One transfer; held until pready is seen, then one idle edge so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) bad_count++;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h00_0000, x});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Poll a busy status until clear, bounded
  task automatic sync(input logic [7:0] a);
    repeat (40) begin
      apb(1'b0, a, 8'h00);
      if (r === 32'h0000_0000) break;
    end
    chk(r, 32'h0000_0000);
  endtask
  // Does the count move over about six source edges; limit 3 keeps it from aliasing
  task automatic moves(input logic x);
    apb(1'b0, 8'h20, 8'h00);
    a0 = r;
    idle(20);
    apb(1'b0, 8'h20, 8'h00);
    chk1(r !== a0, x);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog, well beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, sleep_standby, debug_halt} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    foreach (rz[i]) rdc(rz[i], 8'h00);
    rdc(8'h28, 8'hFF);
    rdc(8'h2C, 8'hFF);
    apb(1'b0, 8'h18, 8'h00);
    chk1(e, 1'b1);
    wr(8'h10, 8'hAB);
    rdc(8'h10, 8'hAB);
    // Limit 3, match 2, count 1, all through the latch
    wr(8'h28, 8'h03);
    wr(8'h2C, 8'h00);
    rdc(8'h04, 8'h04);
    sync(8'h04);
    wr(8'h30, 8'h02);
    wr(8'h34, 8'h00);
    rdc(8'h04, 8'h08);
    sync(8'h04);
    wr(8'h20, 8'h01);
    wr(8'h24, 8'h00);
    rdc(8'h04, 8'h02);
    sync(8'h04);
    rdc(8'h20, 8'h01);
    rdc(8'h28, 8'h03);
    rdc(8'h2C, 8'h00);
    wr(8'h08, 8'h03);
    wr(8'h00, 8'h01);
    rdc(8'h04, 8'h01);
    sync(8'h04);
    idle(40);
    rdc(8'h0C, 8'h03);
    chk1(irq_counter, 1'b1);
    wr(8'h00, 8'h00);
    sync(8'h04);
    idle(8);
    wr(8'h0C, 8'h01);
    rdc(8'h0C, 8'h02);
    chk1(irq_counter, 1'b1);
    wr(8'h0C, 8'h00);
    rdc(8'h0C, 8'h02);
    wr(8'h0C, 8'h02);
    rdc(8'h0C, 8'h00);
    chk1(irq_counter, 1'b0);
    moves(1'b0);
    wr(8'h00, 8'h01);
    sync(8'h04);
    moves(1'b1);
    sleep_standby <= 1'b1;
    moves(1'b0);
    wr(8'h00, 8'h81);
    sync(8'h04);
    moves(1'b1);
    sleep_standby <= 1'b0;
    debug_halt <= 1'b1;
    moves(1'b0);
    wr(8'h14, 8'h01);
    moves(1'b1);
    debug_halt <= 1'b0;
    wr(8'h00, 8'h79);
    sync(8'h04);
    moves(1'b0);
    wr(8'h00, 8'h01);
    sync(8'h04);
    // Every source code runs the counter from its own input
    for (int k = 0; k < 4; k++) begin
      sm <= 4'h1 << k;
      wr(8'h1C, 8'(k));
      moves(1'b1);
    end
    sm <= 4'h1;
    moves(1'b0);
    wr(8'h1C, 8'h00);
    wr(8'h00, 8'h00);
    sync(8'h04);
    // The source runs above left wrap and match set; clear them before the tick part
    wr(8'h0C, 8'h03);
    rdc(8'h0C, 8'h00);
    // Tick period of four source edges
    wr(8'h48, 8'h01);
    wr(8'h40, 8'h09);
    rdc(8'h44, 8'h01);
    sync(8'h44);
    idle(40);
    rdc(8'h4C, 8'h01);
    chk1(irq_tick, 1'b1);
    chk1(irq_counter, 1'b0);
    sleep_standby <= 1'b1;
    wr(8'h4C, 8'h01);
    idle(40);
    rdc(8'h4C, 8'h01);
    sleep_standby <= 1'b0;
    debug_halt <= 1'b1;
    idle(8);
    wr(8'h4C, 8'h01);
    idle(40);
    rdc(8'h4C, 8'h00);
    chk1(irq_tick, 1'b0);
    debug_halt <= 1'b0;
    // Halt while the tick output is high; the release gives a fresh edge
    wr(8'h40, 8'h19);
    sync(8'h44);
    wr(8'h4C, 8'h01);
    repeat (40) begin
      apb(1'b0, 8'h4C, 8'h00);
      if (r === 32'h0000_0001) break;
    end
    debug_halt <= 1'b1;
    wr(8'h4C, 8'h01);
    idle(4);
    debug_halt <= 1'b0;
    idle(2);
    rdc(8'h4C, 8'h01);
    wr(8'h40, 8'h01);
    sync(8'h44);
    wr(8'h4C, 8'h01);
    idle(40);
    rdc(8'h4C, 8'h00);
    wr(8'h00, 8'hFF);
    rdc(8'h00, 8'hF9);
    tally_and_finish();
  end
endmodule
